// ==== src/ugc_pkg.sv ====
// constants shared by the general control block and its interrupt unit
package ugc_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFF  = 8'h00;
    localparam logic [7:0] STAT_OFF  = 8'h04;
    localparam logic [7:0] CLR_OFF   = 8'h08;
    localparam logic [7:0] IEN_OFF   = 8'h0c;
    localparam logic [7:0] DCTRL_OFF = 8'h10;
    // general control field positions
    localparam int unsigned CTRL_EN_BIT   = 0;
    localparam int unsigned CTRL_FRZ_BIT  = 1;
    localparam int unsigned CTRL_PAD_BIT  = 2;
    localparam int unsigned CTRL_POL_BIT  = 3;
    localparam int unsigned CTRL_SEL_BIT  = 4;
    localparam int unsigned CTRL_MODE_BIT = 5;
    localparam int unsigned CTRL_VREQ_BIT = 6;
    // device general control field position
    localparam int unsigned DCTRL_LS_BIT = 0;
    // general status field positions (flags sit in bits 5:0)
    localparam int unsigned STAT_PLUG_BIT   = 8;
    localparam int unsigned STAT_VBUS_BIT   = 9;
    localparam int unsigned STAT_HOST_BIT   = 10;
    localparam int unsigned STAT_ACTIVE_BIT = 11;
    // interrupt flag indices
    localparam int unsigned NUM_FLAGS    = 6;
    localparam int unsigned FLG_PLUG     = 0;
    localparam int unsigned FLG_VBUS     = 1;
    localparam int unsigned FLG_ROLE     = 2;
    localparam int unsigned FLG_VBERR    = 3;
    localparam int unsigned FLG_BCERR    = 4;
    localparam int unsigned FLG_SUSP_TO  = 5;
    // flags that may still raise the request while the clock is frozen
    localparam logic [5:0] ASYNC_MASK = 6'h03;
    // reset values
    localparam logic       FRZ_RESET   = 1'h1;
    localparam logic [5:0] IEN_RESET   = 6'h00;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    // controller role
    typedef enum logic [1:0] {
        UGC_OFF    = 2'b00,
        UGC_DEVICE = 2'b01,
        UGC_HOST   = 2'b10
    } ugc_role_type;
endpackage : ugc_pkg

// ==== src/ugc_irq_if.sv ====
// signals between the control block and its interrupt flag unit
`timescale 1ns/100ps
interface ugc_irq_if;
    logic [5:0] set_evt;   // hardware events, one cycle each
    logic [5:0] clr;       // software write-one-to-clear
    logic       clr_all;   // controller disabled: drop every flag
    logic [5:0] ien;       // per-flag enables
    logic       frozen;    // clock freeze in force
    logic       wake;      // asynchronous wake-up sources, level
    logic       core_irq;  // device or host role interrupts, level
    logic [5:0] flags;
    logic       irq;
    modport ctrl (output set_evt, clr, clr_all, ien, frozen, wake, core_irq,
                  input flags, irq);
    modport unit (input set_evt, clr, clr_all, ien, frozen, wake, core_irq,
                  output flags, irq);
endinterface : ugc_irq_if

// ==== src/ugc_irq_unit.sv ====
// sticky general interrupt flags merged onto one request line
`timescale 1ns/100ps
module ugc_irq_unit (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    ugc_irq_if.unit   ifc
);
    typedef struct packed {
        logic [5:0] flags;
        logic       irq;
    } ugc_irq_state_type;

    ugc_irq_state_type st_reg;
    ugc_irq_state_type st_next;
    logic [5:0]        flag_next;
    logic [5:0]        gate;

    // per flag: set wins over a software clear in the same cycle
    genvar i;
    generate
        for (i = 0; i < 6; i++) begin : g_flag
            assign flag_next[i] = ifc.set_evt[i]
                | (st_reg.flags[i] & ~ifc.clr[i] & ~ifc.clr_all);
        end
    endgenerate

    // frozen clock lets only the asynchronous flags through
    assign gate = ifc.frozen ? ugc_pkg::ASYNC_MASK : 6'h3f;

    // one request for all sources, level while any enabled flag that passes the freeze gate is set
    always_comb begin
        st_next       = st_reg;
        st_next.flags = flag_next;
        st_next.irq   = (|(flag_next & ifc.ien & gate))
                      | ifc.wake
                      | (ifc.core_irq & ~ifc.frozen);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.flags <= ugc_pkg::FLAGS_RESET;
            st_reg.irq   <= 1'h0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign ifc.flags = st_reg.flags;
    assign ifc.irq   = st_reg.irq;
endmodule : ugc_irq_unit

// ==== src/ugc_top.sv ====
// general control of the usb controller: enable, role, freeze, interrupts
//
// Overview of operation
// - hardware reset disables; enabled runs device or host
// - sense pin high: status set, device role
// - sense pin low: status cleared, host role
// - enable bit reads zero after reset
// - clock freeze bit set after reset
// - transceiver held in suspend during reset
// - reset clears device and host role logic
// - buffer RAM untouched and reachable in reset
// - plug and bus-power status follow pins always
// - setup bits writable disabled, applied when running
// - enabling enters selected role in idle
// - clearing enable resets all but setup bits
// - all sources merged onto one request
// - plug, bus-power and role exchange flags
// - bus-power error, b-connection, suspend time-out flags
// - keeps running in idle sleep, irq wakes
// - only asynchronous sources wake in standby
// - bus-power flag set on either edge
// - frozen: only asynchronous sources raise request
`timescale 1ns/100ps
module ugc_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        plug_type_sense_pin,
    input  wire logic        bus_power_level,
    input  wire logic        role_exchange_evt,
    input  wire logic        bus_power_error_evt,
    input  wire logic        b_connection_error_evt,
    input  wire logic        suspend_timeout_evt,
    input  wire logic        wakeup_src,
    input  wire logic        host_wakeup_src,
    input  wire logic        core_irq_src,
    output logic             usb_irq,
    output logic             role_host,
    output logic             core_reset_n,
    output logic             core_clock_run,
    output logic             utmi_suspend,
    output logic             pad_enable_out,
    output logic             low_speed_out,
    output logic             bus_power_switch_out
);
    typedef struct packed {
        logic                 en;
        logic                 frz;
        logic                 pad;
        logic                 pol;
        logic                 sel;
        logic                 mode;
        logic                 vreq;
        logic [5:0]           ien;
        logic                 ls;
        ugc_pkg::ugc_role_type role;
        logic                 host;
        logic                 plug_d;
        logic                 vbus_d;
        logic                 pad_app;
        logic                 pol_app;
        logic                 ls_app;
        logic                 vbof;
        logic                 susp;
        logic                 clk_run;
        logic                 core_rst_n;
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
    } ugc_top_state_type;

    ugc_top_state_type st_reg;
    ugc_top_state_type st_next;
    ugc_irq_if         ifc ();
    logic              setup_ph;
    logic              wr_go;
    logic              eff_id;
    logic              active;

    // true when the offset names a register of this block
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == ugc_pkg::CTRL_OFF) || (a == ugc_pkg::STAT_OFF)
            || (a == ugc_pkg::CLR_OFF) || (a == ugc_pkg::IEN_OFF)
            || (a == ugc_pkg::DCTRL_OFF);
    endfunction : is_mapped

    // bus phases: answer prepared in setup, write lands on the ready edge
    assign setup_ph = psel & ~penable;
    assign wr_go    = psel & penable & st_reg.pready & pwrite;
    // role source: sense pin or software mode bit, high means device
    assign eff_id   = st_reg.sel ? plug_type_sense_pin : st_reg.mode;
    assign active   = st_reg.en & ~st_reg.frz;

    // events and controls toward the interrupt unit
    assign ifc.set_evt[ugc_pkg::FLG_PLUG]    = st_reg.en
        & (plug_type_sense_pin != st_reg.plug_d);
    assign ifc.set_evt[ugc_pkg::FLG_VBUS]    = st_reg.en
        & (bus_power_level != st_reg.vbus_d);
    assign ifc.set_evt[ugc_pkg::FLG_ROLE]    = st_reg.en & role_exchange_evt;
    assign ifc.set_evt[ugc_pkg::FLG_VBERR]   = st_reg.en & bus_power_error_evt;
    assign ifc.set_evt[ugc_pkg::FLG_BCERR]   = st_reg.en & b_connection_error_evt;
    assign ifc.set_evt[ugc_pkg::FLG_SUSP_TO] = st_reg.en & suspend_timeout_evt;
    assign ifc.clr      = (wr_go && paddr == ugc_pkg::CLR_OFF) ? pwdata[5:0] : 6'h00;
    assign ifc.clr_all  = ~st_reg.en;
    assign ifc.ien      = st_reg.ien;
    assign ifc.frozen   = st_reg.frz;
    // wake sources act in any sleep state, so idle sleep wakes too
    assign ifc.wake     = wakeup_src | host_wakeup_src;
    assign ifc.core_irq = core_irq_src & st_reg.en;

    ugc_irq_unit u_irq (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .ifc     (ifc)
    );

    // next state: bus slave, role machine, pin tracking, applied outputs
    always_comb begin
        st_next = st_reg;
        // status mirrors of the pins run even while disabled
        st_next.plug_d = plug_type_sense_pin;
        st_next.vbus_d = bus_power_level;
        // bus answer
        st_next.pready  = 1'h0;
        st_next.pslverr = 1'h0;
        if (setup_ph) begin
            st_next.pready  = 1'h1;
            st_next.pslverr = ~is_mapped(paddr);
            st_next.prdata  = 32'h0000_0000;
            case (paddr)
                ugc_pkg::CTRL_OFF: begin
                    st_next.prdata[ugc_pkg::CTRL_EN_BIT]   = st_reg.en;
                    st_next.prdata[ugc_pkg::CTRL_FRZ_BIT]  = st_reg.frz;
                    st_next.prdata[ugc_pkg::CTRL_PAD_BIT]  = st_reg.pad;
                    st_next.prdata[ugc_pkg::CTRL_POL_BIT]  = st_reg.pol;
                    st_next.prdata[ugc_pkg::CTRL_SEL_BIT]  = st_reg.sel;
                    st_next.prdata[ugc_pkg::CTRL_MODE_BIT] = st_reg.mode;
                    st_next.prdata[ugc_pkg::CTRL_VREQ_BIT] = st_reg.vreq;
                end
                ugc_pkg::STAT_OFF: begin
                    st_next.prdata[5:0] = ifc.flags;
                    st_next.prdata[ugc_pkg::STAT_PLUG_BIT]   = st_reg.plug_d;
                    st_next.prdata[ugc_pkg::STAT_VBUS_BIT]   = st_reg.vbus_d;
                    st_next.prdata[ugc_pkg::STAT_HOST_BIT]   = st_reg.role == ugc_pkg::UGC_HOST;
                    st_next.prdata[ugc_pkg::STAT_ACTIVE_BIT] = active;
                end
                ugc_pkg::IEN_OFF:   st_next.prdata[5:0] = st_reg.ien;
                ugc_pkg::DCTRL_OFF: st_next.prdata[ugc_pkg::DCTRL_LS_BIT] = st_reg.ls;
                default:            st_next.prdata = 32'h0000_0000;
            endcase
        end
        // register writes, accepted whether enabled or not, except IEN and the vreq bit, which stay cleared while disabled
        if (wr_go) begin
            case (paddr)
                ugc_pkg::CTRL_OFF: begin
                    st_next.en   = pwdata[ugc_pkg::CTRL_EN_BIT];
                    st_next.frz  = pwdata[ugc_pkg::CTRL_FRZ_BIT];
                    st_next.pad  = pwdata[ugc_pkg::CTRL_PAD_BIT];
                    st_next.pol  = pwdata[ugc_pkg::CTRL_POL_BIT];
                    st_next.sel  = pwdata[ugc_pkg::CTRL_SEL_BIT];
                    st_next.mode = pwdata[ugc_pkg::CTRL_MODE_BIT];
                    st_next.vreq = pwdata[ugc_pkg::CTRL_VREQ_BIT];
                end
                ugc_pkg::IEN_OFF:   st_next.ien = pwdata[5:0];
                ugc_pkg::DCTRL_OFF: st_next.ls  = pwdata[ugc_pkg::DCTRL_LS_BIT];
                default:            st_next.ls  = st_reg.ls;
            endcase
        end
        // disabled acts as reset except for the setup bits
        if (!st_reg.en) begin
            st_next.ien  = ugc_pkg::IEN_RESET;
            st_next.vreq = 1'h0;
        end
        // role machine: off until enabled, then follows the plug type
        case (st_reg.role)
            ugc_pkg::UGC_OFF: begin
                if (st_reg.en) begin
                    st_next.role = eff_id ? ugc_pkg::UGC_DEVICE
                                          : ugc_pkg::UGC_HOST;
                end
            end
            ugc_pkg::UGC_DEVICE: begin
                if (!st_reg.en) begin
                    st_next.role = ugc_pkg::UGC_OFF;
                end else if (!eff_id) begin
                    st_next.role = ugc_pkg::UGC_HOST;
                end
            end
            ugc_pkg::UGC_HOST: begin
                if (!st_reg.en) begin
                    st_next.role = ugc_pkg::UGC_OFF;
                end else if (eff_id) begin
                    st_next.role = ugc_pkg::UGC_DEVICE;
                end
            end
            default: st_next.role = ugc_pkg::UGC_OFF;
        endcase
        // setup bits reach the pads only while enabled and unfrozen
        if (active) begin
            st_next.pad_app = st_reg.pad;
            st_next.pol_app = st_reg.pol;
            st_next.ls_app  = st_reg.ls;
        end
        // bus-power switch: polarity set means active low output
        st_next.vbof       = (st_reg.vreq & st_reg.en) ^ st_reg.pol_app;
        st_next.susp       = ~active;
        st_next.clk_run    = active;
        // role logic reset; the buffer RAM is outside it and stays readable
        st_next.core_rst_n = st_reg.en;
        // host indication registered together with the role it decodes
        st_next.host       = st_next.role == ugc_pkg::UGC_HOST;
    end

    // state register; reset leaves the controller disabled and frozen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg            <= '0;
            st_reg.frz        <= ugc_pkg::FRZ_RESET;
            st_reg.susp       <= 1'h1;
            st_reg.role       <= ugc_pkg::UGC_OFF;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flip-flops
    assign prdata               = st_reg.prdata;
    assign pready               = st_reg.pready;
    assign pslverr              = st_reg.pslverr;
    assign usb_irq              = ifc.irq;
    assign role_host            = st_reg.host;
    assign core_reset_n         = st_reg.core_rst_n;
    assign core_clock_run       = st_reg.clk_run;
    assign utmi_suspend         = st_reg.susp;
    assign pad_enable_out       = st_reg.pad_app;
    assign low_speed_out        = st_reg.ls_app;
    assign bus_power_switch_out = st_reg.vbof;

    // checks on the control behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    enable_write_a: assert property (
        clk_en && wr_go && paddr == ugc_pkg::CTRL_OFF
        && pwdata[ugc_pkg::CTRL_EN_BIT] && !st_reg.en
        |=> st_reg.en && st_reg.role == ugc_pkg::UGC_OFF
        ##1 (!$past(clk_en) || st_reg.role != ugc_pkg::UGC_OFF))
        else $error("enable did not enter a role");
    host_select_a: assert property (
        clk_en && st_reg.en && st_reg.role == ugc_pkg::UGC_DEVICE && !eff_id
        |=> role_host)
        else $error("low plug type did not select host");
    device_select_a: assert property (
        clk_en && st_reg.en && st_reg.role == ugc_pkg::UGC_HOST && eff_id
        |=> !role_host && st_reg.role == ugc_pkg::UGC_DEVICE)
        else $error("high plug type did not select device");
    plug_status_a: assert property (
        clk_en |=> st_reg.plug_d == $past(plug_type_sense_pin)
                   && st_reg.vbus_d == $past(bus_power_level))
        else $error("status does not follow pins");
    suspend_held_a: assert property (
        clk_en && !st_reg.en |=> utmi_suspend && !core_clock_run && !core_reset_n)
        else $error("transceiver not suspended while disabled");
    disable_reset_a: assert property (
        clk_en && !st_reg.en |=> st_reg.ien == 6'h00 && ifc.flags == 6'h00
        && st_reg.role == ugc_pkg::UGC_OFF)
        else $error("disable did not reset role state");
    vbus_flag_a: assert property (
        clk_en && st_reg.en && bus_power_level != st_reg.vbus_d
        |=> ifc.flags[ugc_pkg::FLG_VBUS])
        else $error("bus power change flag missed");
    freeze_gate_a: assert property (
        usb_irq && $past(clk_en) && $past(st_reg.frz) && !$past(wakeup_src)
        && !$past(host_wakeup_src)
        |-> |(ifc.flags & $past(st_reg.ien) & ugc_pkg::ASYNC_MASK))
        else $error("frozen request from a synchronous source");
    apply_setup_a: assert property (
        clk_en && !active ##1 clk_en && !active |=> $stable(pad_enable_out))
        else $error("setup bit applied while not running");

    enter_host_c:  cover property (st_reg.role == ugc_pkg::UGC_OFF ##1 role_host);
    frozen_irq_c:  cover property (st_reg.frz && usb_irq);
    disable_c:     cover property (st_reg.en ##1 !st_reg.en);
    sw_clear_c:    cover property (wr_go && paddr == ugc_pkg::CLR_OFF);
endmodule : ugc_top

// ==== verif/ugc_cable_model.sv ====
// cable-side model: plug sense line, bus power level, link events and wake-ups
`timescale 1ns/100ps
module ugc_cable_model (
    input  wire logic       pclk,
    output logic            plug_type_sense_pin,
    output logic            bus_power_level,
    output logic [3:0]      evt,
    output logic [1:0]      wake
);
    logic grounded;
    // the sense line is pulled up unless the plug grounds it
    assign plug_type_sense_pin = ~grounded;
    initial begin
        grounded = 1'b0;
        bus_power_level = 1'b0;
        evt = 4'h0;
        wake = 2'h0;
    end
    // one-cycle event pulse launched just after a rising edge
    task automatic pulse(input int i);
        @(posedge pclk);
        evt[i] <= 1'b1;
        @(posedge pclk);
        evt[i] <= 1'b0;
    endtask : pulse
endmodule : ugc_cable_model

// ==== verif/test_ugc_top.sv ====
// self-checking bench of the usb general control block
`timescale 1ns/100ps
module test_ugc_top;
    logic        pclk, presetn, psel, penable, pwrite, core_irq_src, err, clk_en;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, usb_irq, role_host, core_reset_n, core_clock_run;
    logic        utmi_suspend, pad_enable_out, low_speed_out, bus_power_switch_out;
    logic        plug, vbus;
    logic [3:0]  evt;
    logic [1:0]  wake;
    int          mismatches, comparisons, cycles;
    ugc_cable_model cable (.pclk, .plug_type_sense_pin(plug), .bus_power_level(vbus),
        .evt, .wake);
    ugc_top DUT (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .plug_type_sense_pin(plug),
        .bus_power_level(vbus), .role_exchange_evt(evt[0]), .bus_power_error_evt(evt[1]),
        .b_connection_error_evt(evt[2]), .suspend_timeout_evt(evt[3]),
        .wakeup_src(wake[0]), .host_wakeup_src(wake[1]), .core_irq_src, .usb_irq,
        .role_host, .core_reset_n, .core_clock_run, .utmi_suspend, .pad_enable_out,
        .low_speed_out, .bus_power_switch_out);
    // clock, cycle ceiling against hangs
    // the transceiver reference is taken as running from time zero
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // answer taken at the rising edge that samples pready high
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask : rd_chk
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask : settle
    // 0 plug change, 1 bus power change, 2..5 event pulses
    task automatic cause(input int i);
        @(posedge pclk);
        if (i == 0) cable.grounded <= ~cable.grounded;
        else if (i == 1) cable.bus_power_level <= ~vbus;
        else cable.pulse(i - 2);
    endtask : cause
    task automatic t_reset;
        check("core_reset_n", core_reset_n, 0);
        check("utmi_suspend", utmi_suspend, 1);
        check("usb_irq", usb_irq, 0);
        rd_chk(ugc_pkg::CTRL_OFF, 32'h2, "ctrl");
        rd_chk(8'h14, 32'h0, "unmapped");
        check("pslverr", err, 1);
        $display("reset test done");
    endtask : t_reset
    task automatic t_status;
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            cable.grounded <= i[0];
            cable.bus_power_level <= i[1];
            settle(3);
            rd_chk(ugc_pkg::STAT_OFF, (i[0] ? 0 : 32'h100) | (i[1] ? 32'h200 : 0), "stat");
        end
        cable.grounded <= 1'b0;
        $display("status test done");
    endtask : t_status
    task automatic t_setup;
        apb(1'b1, ugc_pkg::CTRL_OFF, 32'h0c);
        apb(1'b1, ugc_pkg::DCTRL_OFF, 32'h1);
        settle(2);
        check("pad idle", pad_enable_out, 0);
        check("ls idle", low_speed_out, 0);
        rd_chk(ugc_pkg::CTRL_OFF, 32'h0c, "ctrl setup");
        apb(1'b1, ugc_pkg::CTRL_OFF, 32'h0d);
        settle(3);
        check("pad run", pad_enable_out, 1);
        check("ls run", low_speed_out, 1);
        check("clock run", core_clock_run, 1);
        check("core out of reset", core_reset_n, 1);
        check("suspend off", utmi_suspend, 0);
        $display("setup test done");
    endtask : t_setup
    task automatic t_role;
        logic [31:0] ctrl [4] = '{32'h11, 32'h11, 32'h21, 32'h01};
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            cable.grounded <= (i == 1);
            apb(1'b1, ugc_pkg::CTRL_OFF, ctrl[i]);
            settle(3);
            check("role_host", role_host, i[0]);
            apb(1'b0, ugc_pkg::STAT_OFF, 32'h0);
            check("host bit", rd[10], i[0]);
        end
        $display("role test done");
    endtask : t_role
    task automatic t_flags;
        apb(1'b1, ugc_pkg::CTRL_OFF, 32'h21);
        apb(1'b1, ugc_pkg::IEN_OFF, 32'h3f);
        apb(1'b1, ugc_pkg::CLR_OFF, 32'h3f);
        for (int i = 0; i < 7; i++) begin
            cause(i % 6 + i / 6);
            settle(2);
            apb(1'b0, ugc_pkg::STAT_OFF, 32'h0);
            check("flags", rd[5:0], 6'h1 << (i % 6 + i / 6));
            check("irq set", usb_irq, 1);
            apb(1'b1, ugc_pkg::CLR_OFF, 32'h3f);
            settle(2);
            check("irq clear", usb_irq, 0);
        end
        cause(5);
        apb(1'b1, ugc_pkg::IEN_OFF, 32'h0);
        settle(2);
        check("irq masked", usb_irq, 0);
        @(posedge pclk);
        core_irq_src <= 1'b1;
        settle(2);
        check("core irq", usb_irq, 1);
        $display("flag test done");
    endtask : t_flags
    task automatic t_freeze;
        apb(1'b1, ugc_pkg::CTRL_OFF, 32'h23);
        apb(1'b1, ugc_pkg::IEN_OFF, 32'h3f);
        apb(1'b1, ugc_pkg::CLR_OFF, 32'h3f);
        // no dma transfer is ever started, so freezing leaves nothing running
        cable.pulse(0);
        settle(3);
        check("frozen irq", usb_irq, 0);
        cause(1);
        settle(2);
        check("frozen bus power", usb_irq, 1);
        apb(1'b1, ugc_pkg::CLR_OFF, 32'h3f);
        cable.wake <= 2'b10;
        settle(2);
        check("host wakeup", usb_irq, 1);
        @(posedge pclk);
        cable.wake <= 2'b00;
        core_irq_src <= 1'b0;
        apb(1'b1, ugc_pkg::IEN_OFF, 32'h3d);
        cause(1);
        settle(2);
        check("vbus irq off", usb_irq, 0);
        $display("freeze test done");
    endtask : t_freeze
    task automatic t_disable;
        apb(1'b1, ugc_pkg::CTRL_OFF, 32'h7d);
        cause(3);
        settle(3);
        check("vbof", bus_power_switch_out, 0);
        apb(1'b1, ugc_pkg::CTRL_OFF, 32'h3c);
        settle(2);
        rd_chk(ugc_pkg::CTRL_OFF, 32'h3c, "ctrl kept");
        rd_chk(ugc_pkg::IEN_OFF, 32'h0, "ien cleared");
        apb(1'b0, ugc_pkg::STAT_OFF, 32'h0);
        check("flags cleared", rd[5:0], 0);
        check("irq off", usb_irq, 0);
        check("core reset", core_reset_n, 0);
        check("suspend", utmi_suspend, 1);
        check("role off", role_host, 0);
        // bus clock gated only after disabling: state must hold still
        @(posedge pclk);
        clk_en <= 1'b0;
        cable.wake <= 2'b01;
        settle(2);
        check("gated irq", usb_irq, 0);
        @(posedge pclk);
        clk_en <= 1'b1;
        settle(2);
        check("wake irq", usb_irq, 1);
        @(posedge pclk);
        cable.wake <= 2'b00;
        $display("disable test done");
    endtask : t_disable
    // reset for 16 cycles, then the scenarios in order
    initial begin
        {presetn, psel, penable, pwrite, core_irq_src} = 5'h0;
        clk_en = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        settle(0);
        t_reset();
        t_status();
        t_setup();
        t_role();
        t_flags();
        t_freeze();
        t_disable();
        complete_run();
    end
endmodule : test_ugc_top
